/* rtl/timer16_cc_consts.vh */
// Constants for the 16-bit timer capture and compare block
`ifndef TIMER16_CC_CONSTS_VH
`define TIMER16_CC_CONSTS_VH
// Register word offsets (byte address bits 5:2)
`define ADR_CTRL 4'h0
`define ADR_CNT 4'h1
`define ADR_CAPT 4'h2
`define ADR_CMPA_LO 4'h3
`define ADR_CMPA_HI 4'h4
`define ADR_CMPB_LO 4'h5
`define ADR_CMPB_HI 4'h6
`define ADR_FLAGS 4'h7
`define ADR_FORCE 4'h8
// Control register fields
`define CTRL_WGM_LSB 0
`define CTRL_COMA_LSB 4
`define CTRL_COMB_LSB 6
`define CTRL_CS_LSB 8
`define CTRL_EDGE 11
`define CTRL_NF 12
`define CTRL_COMPARATOR_CAPTURE_SELECT 13
`define CTRL_IEA 14
`define CTRL_IEB 15
`define CTRL_IEC 16
`define CTRL_W 17
// Flag bits
`define FLG_CAP 0
`define FLG_A 1
`define FLG_B 2
// Waveform modes of interest
`define WGM_NORMAL 4'h0
`define WGM_CTC_A 4'h4
`define WGM_CTC_I 4'hc
`define WGM_FAST_I 4'he
`define WGM_FAST_A 4'hf
`define WGM_PFC_I 4'h8
`define WGM_PFC_A 4'h9
`define WGM_PC_I 4'ha
`define WGM_PC_A 4'hb
`define WGM_RSVD 4'hd
// Output actions
`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3
// Filter sample count
`define NF_SAMPLES 4
`define MAX16 16'hffff
`define ZERO16 16'h0000
`endif

/* rtl/timer16_capture_compare.v */
// Capture trigger path and compare units of a 16-bit timer
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`include "timer16_cc_consts.vh"
module timer16_capture_compare (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire capture_input_pin_i,
  input wire comparator_output_i,
  input wire timer_tick_i,
  input wire [15:0] counter_value_i,
  input wire counter_write_i,
  input wire count_up_i,
  input wire at_top_i,
  input wire at_bottom_i,
  input wire irq_ack_capt_i,
  input wire irq_ack_a_i,
  input wire irq_ack_b_i,
  output reg capture_flag_o,
  output reg compare_flag_a_o,
  output reg compare_flag_b_o,
  output wire irq_capt_o,
  output wire irq_a_o,
  output wire irq_b_o,
  output wire [15:0] top_value_o,
  output wire top_from_a_o,
  output wire top_from_capt_o,
  output reg compare_output_a_o,
  output reg compare_output_b_o,
  output wire [3:0] waveform_mode_bits_o,
  output wire [2:0] clock_select_o
);

  // PWM mode decode, used by both units
  function is_pwm;
    input [3:0] m;
    begin
      is_pwm = !(m == `WGM_NORMAL || m == `WGM_CTC_A || m == `WGM_CTC_I || m == `WGM_RSVD);
    end
  endfunction

  // Next output value for a given action
  function act_out;
    input [1:0] com;
    input cur;
    begin
      case (com)
        `COM_TOGGLE: act_out = ~cur;
        `COM_CLEAR: act_out = 1'b0;
        `COM_SET: act_out = 1'b1;
        default: act_out = cur;
      endcase
    end
  endfunction

  reg [`CTRL_W-1:0] ctrl_r;
  reg [15:0] capt_r;
  reg [7:0] temp_r;
  reg [15:0] cmp_buf_r [0:1];
  reg [15:0] cmp_work_r [0:1];
  reg block_r;
  reg [1:0] match_d_r;
  reg [1:0] pin_sync_r;
  reg [1:0] aco_sync_r;
  reg [`NF_SAMPLES-1:0] nf_hist_r;
  reg nf_out_r;
  reg edge_prev_r;

  wire [3:0] wgm = ctrl_r[`CTRL_WGM_LSB +: 4];
  wire [1:0] com_a = ctrl_r[`CTRL_COMA_LSB +: 2];
  wire [1:0] com_b = ctrl_r[`CTRL_COMB_LSB +: 2];
  wire pwm = is_pwm(wgm);
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire [3:0] word_adr = wb_adr_i[5:2];
  wire capt_is_top = (wgm == `WGM_CTC_I) || (wgm == `WGM_FAST_I) ||
    (wgm == `WGM_PFC_I) || (wgm == `WGM_PC_I);

  assign waveform_mode_bits_o = wgm;
  assign clock_select_o = ctrl_r[`CTRL_CS_LSB +: 3];
  // Compare A or capture register as counter top
  assign top_from_a_o = (wgm == `WGM_CTC_A) || (wgm == `WGM_FAST_A) ||
    (wgm == `WGM_PFC_A) || (wgm == `WGM_PC_A);
  assign top_from_capt_o = capt_is_top;
  assign top_value_o = top_from_a_o ? cmp_work_r[0] : capt_r;

  // Interrupt requests
  assign irq_capt_o = capture_flag_o & ctrl_r[`CTRL_IEC];
  assign irq_a_o = compare_flag_a_o & ctrl_r[`CTRL_IEA];
  assign irq_b_o = compare_flag_b_o & ctrl_r[`CTRL_IEB];

  // Two-stage synchronisers; pin read whatever drives it
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_sync_r <= 2'h0;
      aco_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], capture_input_pin_i};
      aco_sync_r <= {aco_sync_r[0], comparator_output_i};
    end
  end

  // Source select
  wire src = ctrl_r[`CTRL_COMPARATOR_CAPTURE_SELECT] ? aco_sync_r[1] : pin_sync_r[1];
  wire nf_all1 = &{nf_hist_r[`NF_SAMPLES-2:0], src};
  wire nf_all0 = ~|{nf_hist_r[`NF_SAMPLES-2:0], src};
  wire det_in = ctrl_r[`CTRL_NF] ? nf_out_r : src;
  // Selected edge; source switch may look like an edge
  wire cap_edge = ~capt_is_top &
    (ctrl_r[`CTRL_EDGE] ? (det_in & ~edge_prev_r) : (~det_in & edge_prev_r));

  // Noise filter on system clock, four equal samples
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      nf_hist_r <= {`NF_SAMPLES{1'b0}};
      nf_out_r <= 1'b0;
      edge_prev_r <= 1'b0;
    end else begin
      nf_hist_r <= {nf_hist_r[`NF_SAMPLES-2:0], src};
      if (nf_all1) begin
        nf_out_r <= 1'b1;
      end else if (nf_all0) begin
        nf_out_r <= 1'b0;
      end
      edge_prev_r <= det_in;
    end
  end

  // Compare matches, gated by counter write blocking
  wire match_a = (counter_value_i == cmp_work_r[0]);
  wire match_b = (counter_value_i == cmp_work_r[1]);
  wire ld_pt = pwm & timer_tick_i &
    ((wgm == `WGM_PFC_I || wgm == `WGM_PFC_A) ? at_bottom_i :
     (wgm == `WGM_PC_I || wgm == `WGM_PC_A) ? at_top_i : at_top_i);
  wire wr_cmp_lo_a = bus_wr && word_adr == `ADR_CMPA_LO;
  wire wr_cmp_lo_b = bus_wr && word_adr == `ADR_CMPB_LO;
  wire wr_cmp_hi = bus_wr && (word_adr == `ADR_CMPA_HI || word_adr == `ADR_CMPB_HI);
  wire wr_flags = bus_wr && word_adr == `ADR_FLAGS;
  wire wr_force = bus_wr && word_adr == `ADR_FORCE && !pwm;
  wire [15:0] cmp_new = {temp_r, wb_dat_i[7:0]};
  wire [1:0] match_ok = {match_b, match_a} & {2{~block_r}};

  // Counter write blocking window, one timer tick
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      block_r <= 1'b0;
    end else if (counter_write_i) begin
      block_r <= 1'b1;
    end else if (timer_tick_i) begin
      block_r <= 1'b0;
    end
  end

  // Control, latch and compare registers
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_r <= {`CTRL_W{1'b0}};
      temp_r <= 8'h00;
      cmp_buf_r[0] <= `ZERO16;
      cmp_buf_r[1] <= `ZERO16;
      cmp_work_r[0] <= `ZERO16;
      cmp_work_r[1] <= `ZERO16;
    end else begin
      if (bus_wr && word_adr == `ADR_CTRL) begin
        ctrl_r <= wb_dat_i[`CTRL_W-1:0];
      end
      if (wr_cmp_hi) begin
        temp_r <= wb_dat_i[7:0];
      end
      // Buffer or working register by mode
      if (wr_cmp_lo_a) begin
        if (pwm) begin
          cmp_buf_r[0] <= cmp_new;
        end else begin
          cmp_work_r[0] <= cmp_new;
        end
      end
      if (wr_cmp_lo_b) begin
        if (pwm) begin
          cmp_buf_r[1] <= cmp_new;
        end else begin
          cmp_work_r[1] <= cmp_new;
        end
      end
      // Update working copies at top or bottom
      if (ld_pt && !wr_cmp_lo_a) begin
        cmp_work_r[0] <= cmp_buf_r[0];
      end
      if (ld_pt && !wr_cmp_lo_b) begin
        cmp_work_r[1] <= cmp_buf_r[1];
      end
    end
  end

  // Capture register and flags; set wins over clear
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      capt_r <= `ZERO16;
      capture_flag_o <= 1'b0;
      compare_flag_a_o <= 1'b0;
      compare_flag_b_o <= 1'b0;
      match_d_r <= 2'h0;
    end else begin
      if (cap_edge) begin
        capt_r <= counter_value_i;
        capture_flag_o <= 1'b1;
      end else if (irq_ack_capt_i || (wr_flags && wb_dat_i[`FLG_CAP])) begin
        capture_flag_o <= 1'b0;
      end else if (bus_wr && word_adr == `ADR_CAPT && capt_is_top) begin
        capt_r <= wb_dat_i[15:0];
      end
      if (timer_tick_i) begin
        match_d_r <= match_ok;
      end
      if (timer_tick_i && match_d_r[0]) begin
        compare_flag_a_o <= 1'b1;
      end else if (irq_ack_a_i || (wr_flags && wb_dat_i[`FLG_A])) begin
        compare_flag_a_o <= 1'b0;
      end
      if (timer_tick_i && match_d_r[1]) begin
        compare_flag_b_o <= 1'b1;
      end else if (irq_ack_b_i || (wr_flags && wb_dat_i[`FLG_B])) begin
        compare_flag_b_o <= 1'b0;
      end
    end
  end

  // Waveform generator, simplified per mode
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      compare_output_a_o <= 1'b0;
      compare_output_b_o <= 1'b0;
    end else if (wr_force) begin
      if (wb_dat_i[0]) begin
        compare_output_a_o <= act_out(com_a, compare_output_a_o);
      end
      if (wb_dat_i[1]) begin
        compare_output_b_o <= act_out(com_b, compare_output_b_o);
      end
    end else if (timer_tick_i) begin
      if (!pwm) begin
        if (match_ok[0]) begin
          compare_output_a_o <= act_out(com_a, compare_output_a_o);
        end
        if (match_ok[1]) begin
          compare_output_b_o <= act_out(com_b, compare_output_b_o);
        end
      end else begin
        // PWM: action clear clears on up-match, sets on down-match or bottom; action set does the reverse
        if (com_a[1] && (match_ok[0] || at_bottom_i)) begin
          compare_output_a_o <= (match_ok[0] && count_up_i) ^ com_a[0] ? 1'b0 : 1'b1;
        end
        if (com_b[1] && (match_ok[1] || at_bottom_i)) begin
          compare_output_b_o <= (match_ok[1] && count_up_i) ^ com_b[0] ? 1'b0 : 1'b1;
        end
      end
    end
  end

  // Wishbone read mux and ack
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (word_adr)
          `ADR_CTRL: wb_dat_o <= {15'h0000, ctrl_r};
          `ADR_CNT: wb_dat_o <= {16'h0000, counter_value_i};
          `ADR_CAPT: wb_dat_o <= {16'h0000, capt_r};
          `ADR_CMPA_LO: wb_dat_o <= {24'h000000, (pwm ? cmp_buf_r[0][7:0] : cmp_work_r[0][7:0])};
          `ADR_CMPA_HI: wb_dat_o <= {24'h000000, (pwm ? cmp_buf_r[0][15:8] : cmp_work_r[0][15:8])};
          `ADR_CMPB_LO: wb_dat_o <= {24'h000000, (pwm ? cmp_buf_r[1][7:0] : cmp_work_r[1][7:0])};
          `ADR_CMPB_HI: wb_dat_o <= {24'h000000, (pwm ? cmp_buf_r[1][15:8] : cmp_work_r[1][15:8])};
          `ADR_FLAGS: wb_dat_o <= {29'h00000000, compare_flag_b_o, compare_flag_a_o, capture_flag_o};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // timer16_capture_compare

/* verification/timer16_cc_properties.sv */
// Port checker for the timer capture and compare block
`timescale 1ns/1ns
module timer16_cc_properties (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire timer_tick_i,
  input wire irq_ack_a_i,
  input wire capture_flag_o,
  input wire compare_flag_a_o,
  input wire compare_flag_b_o,
  input wire irq_capt_o,
  input wire irq_a_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Bus answers one cycle after taking, for one cycle
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i == 6'h3c |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  // Compare flags set only on timer ticks
  flag_a_tick_a: assert property ($rose(compare_flag_a_o) |-> $past(timer_tick_i))
    else $error("flag a off tick");
  flag_b_tick_a: assert property ($rose(compare_flag_b_o) |-> $past(timer_tick_i))
    else $error("flag b off tick");
  irq_a_gate_a: assert property (irq_a_o |-> compare_flag_a_o)
    else $error("irq a without flag");
  irq_capt_gate_a: assert property (irq_capt_o |-> capture_flag_o)
    else $error("irq capt without flag");
  ack_clears_a: assert property (irq_ack_a_i && !timer_tick_i |=> !compare_flag_a_o)
    else $error("flag a kept after ack");
endmodule // timer16_cc_properties
bind timer16_capture_compare timer16_cc_properties chk (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_tick_i(timer_tick_i), .irq_ack_a_i(irq_ack_a_i), .capture_flag_o(capture_flag_o),
  .compare_flag_a_o(compare_flag_a_o), .compare_flag_b_o(compare_flag_b_o),
  .irq_capt_o(irq_capt_o), .irq_a_o(irq_a_o));

/* verification/event_source_model.sv */
// Far side model: counter value, timer tick and event lines
`timescale 1ns/1ns
module event_source_model (
  input wire clk_sys_i,
  output logic pin_o,
  output logic comp_o,
  output logic tick_o,
  output logic [15:0] count_o
);
  initial begin
    pin_o = 1'b0;
    comp_o = 1'b0;
    tick_o = 1'b0;
    count_o = 16'h0000;
  end
  // Pin driven like a port output
  task drive(input logic p, input logic c);
    @(posedge clk_sys_i);
    pin_o <= p;
    comp_o <= c;
  endtask
  task load(input logic [15:0] v);
    @(posedge clk_sys_i);
    count_o <= v;
  endtask
  // One-cycle prescaled tick
  task tick;
    @(posedge clk_sys_i);
    tick_o <= 1'b1;
    @(posedge clk_sys_i);
    tick_o <= 1'b0;
  endtask
endmodule // event_source_model

/* verification/timer16_capture_compare_tb.sv */
// Testbench for the timer capture and compare block
`timescale 1ns/1ns
`include "timer16_cc_consts.vh"
module timer16_capture_compare_tb;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cw = 1'b0, iack = 1'b0, cack = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0, rd;
  wire [31:0] rdat;
  wire [15:0] cnt;
  wire ack, pin, cmp, tick, fc, fa, fb, irqa, irqc, oa;
  int bad_count = 0, compares = 0, d0, d1;
  localparam logic [31:0] cap_ctrl = (32'h1 << `CTRL_EDGE) | (32'h1 << `CTRL_IEC);
  initial forever #25 clk_sys_i = ~clk_sys_i;
  event_source_model src (.clk_sys_i(clk_sys_i), .pin_o(pin), .comp_o(cmp), .tick_o(tick),
    .count_o(cnt));
  timer16_capture_compare uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .capture_input_pin_i(pin), .comparator_output_i(cmp),
    .timer_tick_i(tick), .counter_value_i(cnt), .counter_write_i(cw), .count_up_i(1'b1),
    .at_top_i(1'b0), .at_bottom_i(1'b0), .irq_ack_capt_i(cack), .irq_ack_a_i(iack),
    .irq_ack_b_i(iack), .capture_flag_o(fc), .compare_flag_a_o(fa), .compare_flag_b_o(fb),
    .irq_capt_o(irqc), .irq_a_o(irqa), .irq_b_o(), .top_value_o(), .top_from_a_o(),
    .top_from_capt_o(), .compare_output_a_o(oa), .compare_output_b_o(),
    .waveform_mode_bits_o(), .clock_select_o());
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Classic single bus cycle, held until ack
  task wbx(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= d;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) bad_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wait_cap(output int n);
    n = 0;
    while (fc !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    check("capture seen", n < 40, 1'b1);
  endtask
  task t_compare;
    src.tick;
    src.tick;
    #1 check("flag b", fb, 1'b1);
    // Move counter off both values so no stale match remains
    src.load(16'h1234);
    src.tick;
    wbx(1, `ADR_FLAGS, 32'h7);
    wbx(1, `ADR_CTRL, 32'h1 << `CTRL_IEA);
    wbx(0, 4'hf, 32'h0);
    check("unmapped", rd, 32'h0);
    wbx(1, `ADR_CMPA_HI, 32'h12);
    wbx(0, `ADR_CMPA_HI, 32'h0);
    check("hi early", rd[7:0], 8'h00);
    wbx(1, `ADR_CMPA_LO, 32'h34);
    wbx(0, `ADR_CMPA_HI, 32'h0);
    check("hi", rd[7:0], 8'h12);
    wbx(0, `ADR_CMPA_LO, 32'h0);
    check("lo", rd[7:0], 8'h34);
    src.tick;
    #1 check("flag early", fa, 1'b0);
    src.tick;
    #1 check("flag a", fa, 1'b1);
    check("irq a", irqa, 1'b1);
    wbx(1, `ADR_FLAGS, 32'h2);
    #1 check("w1c", fa, 1'b0);
    $display("compare test done");
  endtask
  task t_block;
    // Flush the match held from the last tick, then clear flag A
    src.load(16'h0000);
    src.tick;
    wbx(1, `ADR_FLAGS, 32'h2);
    src.load(16'h1234);
    @(posedge clk_sys_i) cw <= 1'b1;
    @(posedge clk_sys_i) cw <= 1'b0;
    src.tick;
    src.tick;
    #1 check("blocked", fa, 1'b0);
    src.tick;
    #1 check("unblocked", fa, 1'b1);
    @(posedge clk_sys_i) iack <= 1'b1;
    @(posedge clk_sys_i) iack <= 1'b0;
    #1 check("ack clear", fa, 1'b0);
    $display("block test done");
  endtask
  task t_force;
    check("out idle", oa, 1'b0);
    wbx(1, `ADR_CTRL, 32'h10);
    wbx(1, `ADR_FORCE, 32'h1);
    wbx(0, `ADR_FLAGS, 32'h0);
    check("forced", oa, 1'b1);
    check("no flag", rd[1], 1'b0);
    wbx(1, `ADR_CTRL, 32'h0);
    wbx(1, `ADR_FORCE, 32'h1);
    wbx(0, `ADR_FLAGS, 32'h0);
    check("no action", oa, 1'b1);
    $display("force test done");
  endtask
  task t_capture;
    wbx(1, `ADR_CTRL, cap_ctrl);
    src.load(16'h00ab);
    src.drive(1'b1, 1'b0);
    wait_cap(d0);
    check("irq capt", irqc, 1'b1);
    wbx(1, `ADR_FLAGS, 32'h1);
    src.drive(1'b0, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    check("fall ignored", fc, 1'b0);
    src.load(16'h00cd);
    src.drive(1'b1, 1'b0);
    wait_cap(d1);
    wbx(0, `ADR_CAPT, 32'h0);
    check("capt", rd[15:0], 16'h00cd);
    $display("capture test done");
  endtask
  task t_filter;
    wbx(1, `ADR_CTRL, cap_ctrl | (32'h1 << `CTRL_NF));
    src.drive(1'b0, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    wbx(1, `ADR_FLAGS, 32'h1);
    src.drive(1'b1, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    src.drive(1'b0, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    check("glitch", fc, 1'b0);
    src.drive(1'b1, 1'b0);
    wait_cap(d1);
    check("filter delay", d1, d0 + 4);
    $display("filter test done");
  endtask
  task t_source;
    wbx(1, `ADR_CTRL, cap_ctrl | (32'h1 << `CTRL_COMPARATOR_CAPTURE_SELECT));
    src.drive(1'b0, 1'b0);
    repeat (8) @(posedge clk_sys_i);
    wbx(1, `ADR_FLAGS, 32'h1);
    src.drive(1'b1, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    check("pin ignored", fc, 1'b0);
    src.drive(1'b1, 1'b1);
    wait_cap(d1);
    check("comparator", fc, 1'b1);
    @(posedge clk_sys_i) cack <= 1'b1;
    @(posedge clk_sys_i) cack <= 1'b0;
    #1 check("capt ack", fc, 1'b0);
    $display("source test done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_compare;
    t_block;
    t_force;
    t_capture;
    t_filter;
    t_source;
    print_verdict;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    print_verdict;
  end
endmodule // timer16_capture_compare_tb
